// [pkg/vipd_defines.vh]
/*
  constants of the video input port demux: mode codes, control bit positions, reset values.
  assumes inclusion by bare name from rtl files.
*/
`ifndef VIPD_DEFINES_VH
`define VIPD_DEFINES_VH
// ----------------------------------------------------------------
// input mode codes
// ----------------------------------------------------------------
`define VIPD_MODE_SD      3'h0
`define VIPD_MODE_HD_SDR  3'h1
`define VIPD_MODE_HD_DDR  3'h2
`define VIPD_MODE_SD_SDR  3'h3
`define VIPD_MODE_SD_DDR  3'h4
`define VIPD_MODE_ED54    3'h7
`define VIPD_MODE_RESET   3'h0
// ----------------------------------------------------------------
// configuration register bit positions
// ----------------------------------------------------------------
`define VIPD_CFG_MODE_HI  6
`define VIPD_CFG_MODE_LO  4
`define VIPD_CFG_SWAP     7
`define VIPD_CFG_EDGE_HI  2
`define VIPD_CFG_EDGE_LO  1
`define VIPD_SDF_WIDE     3
`define VIPD_SDF_HI       4
`define VIPD_SDF_LO       3
`define VIPD_CFG_RESET    8'h00
// ----------------------------------------------------------------
// output path tags and sync pin width
// ----------------------------------------------------------------
`define VIPD_PATH_SD      1'b0
`define VIPD_PATH_HD      1'b1
`define VIPD_SYNC_W       3
`endif

// [rtl/vipd_fifo.v]
/*
  synchronous fifo with parameterised width and depth, valid/ready on both sides.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module vipd_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clk,
  input wire srst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];
  always @(posedge clk) begin
    if (srst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule // vipd_fifo

// [rtl/vipd_port.v]
/*
  video input port demux: samples the s, y and c pixel buses and steers components by mode.
  assumes pixel clocks are sampled by clk (125 MHz), faster than twice the pixel rate.
*/
// What this block does
// - input mode comes from bits 6..4 of configuration byte cfg_input
// - after reset the mode code is 000, sd only
// - 001 selects hd single rate, 010 selects hd dual rate on one bus
// - sd 8-bit 4:2:2 from s bus, or y bus when swap set
// - sd 16-bit: luma s, chroma y; swapped luma y, chroma c
// - sd rgb select: red s, green y, blue c
// - sd 16-bit and rgb modes use external syncs only, no embedded codes
// - sd ycrcb data format follows bits 4..3 of sd format byte
// - hd single rate format 4:2:2 or 4:4:4 follows hd_422_select
// - hd 16-bit 4:2:2: luma y bus, chroma c bus
// - hd dual rate: luma on one clock edge, chroma on the other, y bus
// - luma capture edge chosen by bits 2..1 of configuration byte
// - dual rate only for 4:2:2 ycrcb, never 4:4:4
// - hd rgb only as 4:4:4 single rate
// - hd 24-bit 4:4:4 ycrcb: luma y, cr s, cb c
// - hd rgb select: red s, green y, blue c
// - 011: sd on s, hd luma y chroma c; 100: sd s, hd dual y
// - 111 is 54 MHz ed only, interleaved ycrcb on y bus
`timescale 1ns/1ps
`include "vipd_defines.vh"
module vipd_port #(
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW = 5
) (
  input wire clk,
  input wire srst,
  input wire [7:0] cfg_input,
  input wire [7:0] sd_format,
  input wire sd_rgb_select,
  input wire hd_rgb_select,
  input wire hd_422_select,
  input wire primary_pixel_clock_pin,
  input wire secondary_pixel_clock_pin,
  input wire [7:0] s_pixel_bus,
  input wire [7:0] y_pixel_bus,
  input wire [7:0] c_pixel_bus,
  input wire [2:0] sd_sync_pins,
  input wire [2:0] hd_sync_pins,
  output reg [2:0] mode,
  output wire mode_reserved,
  output wire [1:0] sd_data_format,
  output wire embedded_sync_allowed,
  output wire pix_valid,
  input wire pix_ready,
  output wire [35:0] pix_data,
  output reg overflow
);
  // ----------------------------------------------------------------
  // pin synchronisers: three stages, change taken when 2nd and 3rd agree
  // ----------------------------------------------------------------
  localparam PW = 2 + 24 + 2 * `VIPD_SYNC_W;
  reg [PW-1:0] sy1;
  reg [PW-1:0] sy2;
  reg [PW-1:0] sy3;
  reg [PW-1:0] pins;
  wire [PW-1:0] raw_pins;
  integer i;
  assign raw_pins = {primary_pixel_clock_pin, secondary_pixel_clock_pin,
                     s_pixel_bus, y_pixel_bus, c_pixel_bus, sd_sync_pins, hd_sync_pins};
  always @(posedge clk) begin
    if (srst) begin
      sy1 <= {PW{1'b0}};
      sy2 <= {PW{1'b0}};
      sy3 <= {PW{1'b0}};
      pins <= {PW{1'b0}};
    end else begin
      sy1 <= raw_pins;
      sy2 <= sy1;
      sy3 <= sy2;
      for (i = 0; i < PW; i = i + 1) begin
        if (sy2[i] == sy3[i]) begin
          pins[i] <= sy3[i];
        end
      end
    end
  end
  wire pclk_a;
  wire pclk_b;
  wire [7:0] s_bus;
  wire [7:0] y_bus;
  wire [7:0] c_bus;
  wire [2:0] sd_sync;
  wire [2:0] hd_sync;
  assign {pclk_a, pclk_b, s_bus, y_bus, c_bus, sd_sync, hd_sync} = pins;
  // ----------------------------------------------------------------
  // mode register
  // ----------------------------------------------------------------
  wire [2:0] next_mode;
  assign next_mode = cfg_input[`VIPD_CFG_MODE_HI:`VIPD_CFG_MODE_LO];
  always @(posedge clk) begin
    if (srst) begin
      mode <= `VIPD_MODE_RESET;
    end else begin
      mode <= next_mode;
    end
  end
  wire bus_swap;
  wire [1:0] luma_edge;
  wire sd_wide;
  assign bus_swap = cfg_input[`VIPD_CFG_SWAP];
  assign luma_edge = cfg_input[`VIPD_CFG_EDGE_HI:`VIPD_CFG_EDGE_LO];
  assign sd_wide = sd_format[`VIPD_SDF_WIDE];
  assign sd_data_format = sd_format[`VIPD_SDF_HI:`VIPD_SDF_LO];
  assign mode_reserved = (mode != `VIPD_MODE_SD) && (mode != `VIPD_MODE_HD_SDR) &&
                         (mode != `VIPD_MODE_HD_DDR) && (mode != `VIPD_MODE_SD_SDR) &&
                         (mode != `VIPD_MODE_SD_DDR) && (mode != `VIPD_MODE_ED54);
  // embedded codes in all modes but sd 16-bit or rgb, hd single rate rgb and reserved codes
  assign embedded_sync_allowed = (mode == `VIPD_MODE_SD) ? (!sd_rgb_select && !sd_wide) :
                                 (mode == `VIPD_MODE_HD_SDR) ? (!hd_rgb_select) :
                                 !mode_reserved;
  // ----------------------------------------------------------------
  // pixel clock edge detection on sampled clocks
  // ----------------------------------------------------------------
  reg pclk_a_d;
  reg pclk_b_d;
  always @(posedge clk) begin
    if (srst) begin
      pclk_a_d <= 1'b0;
      pclk_b_d <= 1'b0;
    end else begin
      pclk_a_d <= pclk_a;
      pclk_b_d <= pclk_b;
    end
  end
  wire a_rise;
  wire a_fall;
  wire b_rise;
  wire b_fall;
  assign a_rise = pclk_a && !pclk_a_d;
  assign a_fall = !pclk_a && pclk_a_d;
  assign b_rise = pclk_b && !pclk_b_d;
  assign b_fall = !pclk_b && pclk_b_d;
  // luma edge: 00 rising, anything else falling
  wire luma_on_rise;
  assign luma_on_rise = (luma_edge == 2'h0);
  // ----------------------------------------------------------------
  // component steering
  // word: path[35] ddr_chroma[34] fmt[33:32] zero[31:27] sync[26:24] c2[23:16] c1[15:8] c0[7:0]
  // ----------------------------------------------------------------
  reg cap;
  reg cap_path;
  reg cap_chroma;
  reg [1:0] cap_fmt;
  reg [2:0] cap_sync;
  reg [7:0] comp0;
  reg [7:0] comp1;
  reg [7:0] comp2;
  reg cap2;
  reg [7:0] hd_y;
  reg [7:0] hd_c;
  reg [7:0] hd_s;
  reg hd_chroma;
  always @* begin
    cap = 1'b0;
    cap_path = `VIPD_PATH_SD;
    cap_chroma = 1'b0;
    cap_fmt = 2'h0;
    cap_sync = sd_sync;
    comp0 = 8'h00;
    comp1 = 8'h00;
    comp2 = 8'h00;
    cap2 = 1'b0;
    hd_y = 8'h00;
    hd_c = 8'h00;
    hd_s = 8'h00;
    hd_chroma = 1'b0;
    case (mode)
      `VIPD_MODE_SD: begin
        cap = a_rise;
        if (sd_rgb_select) begin
          comp0 = s_bus;
          comp1 = y_bus;
          comp2 = c_bus;
          cap_fmt = 2'h3;
        end else if (sd_wide) begin
          comp0 = bus_swap ? y_bus : s_bus;
          comp1 = bus_swap ? c_bus : y_bus;
          cap_fmt = 2'h1;
        end else begin
          comp0 = bus_swap ? y_bus : s_bus;
          cap_fmt = 2'h0;
        end
      end
      `VIPD_MODE_HD_SDR: begin
        cap = a_rise;
        cap_path = `VIPD_PATH_HD;
        cap_sync = hd_sync;
        comp0 = y_bus;
        if (hd_rgb_select) begin
          comp0 = s_bus;
          comp1 = y_bus;
          comp2 = c_bus;
          cap_fmt = 2'h3;
        end else if (hd_422_select) begin
          comp1 = c_bus;
          cap_fmt = 2'h1;
        end else begin
          comp1 = s_bus;
          comp2 = c_bus;
          cap_fmt = 2'h2;
        end
      end
      `VIPD_MODE_HD_DDR: begin
        // ddr always treated as 4:2:2 ycrcb, rgb/444 selects ignored
        cap = a_rise || a_fall;
        cap_path = `VIPD_PATH_HD;
        cap_sync = hd_sync;
        cap_chroma = luma_on_rise ? a_fall : a_rise;
        comp0 = y_bus;
        cap_fmt = 2'h0;
      end
      `VIPD_MODE_SD_SDR, `VIPD_MODE_SD_DDR: begin
        cap = a_rise;
        comp0 = s_bus;
        hd_y = y_bus;
        hd_c = (mode == `VIPD_MODE_SD_SDR) ? c_bus : 8'h00;
        hd_chroma = (mode == `VIPD_MODE_SD_DDR) && (luma_on_rise ? b_fall : b_rise);
        cap2 = (mode == `VIPD_MODE_SD_SDR) ? b_rise : (b_rise || b_fall);
        hd_s = 8'h00;
      end
      `VIPD_MODE_ED54: begin
        cap = a_rise;
        cap_path = `VIPD_PATH_HD;
        cap_sync = hd_sync;
        comp0 = y_bus;
        cap_fmt = 2'h0;
      end
      default: begin
        cap = 1'b0;
      end
    endcase
  end
  // ----------------------------------------------------------------
  // capture register, hd word of simultaneous modes takes a second slot
  // ----------------------------------------------------------------
  reg [35:0] word_a;
  reg [35:0] word_b;
  reg valid_a;
  reg valid_b;
  wire f_ready;
  wire f_valid;
  wire [35:0] f_data;
  assign f_valid = valid_a || valid_b;
  assign f_data = valid_a ? word_a : word_b;
  always @(posedge clk) begin
    if (srst) begin
      word_a <= 36'h0;
      word_b <= 36'h0;
      valid_a <= 1'b0;
      valid_b <= 1'b0;
      overflow <= 1'b0;
    end else begin
      if (cap) begin
        word_a <= {cap_path, cap_chroma, cap_fmt, 5'h00, cap_sync, comp2, comp1, comp0};
        valid_a <= 1'b1;
      end else if (valid_a && f_ready) begin
        valid_a <= 1'b0;
      end
      if (cap2) begin
        word_b <= {`VIPD_PATH_HD, hd_chroma, ((mode == `VIPD_MODE_SD_SDR) ? 2'h1 : 2'h0), 5'h00, hd_sync, hd_s, hd_c,
                   hd_y};
        valid_b <= 1'b1;
      end else if (!valid_a && valid_b && f_ready) begin
        valid_b <= 1'b0;
      end
      if ((cap && valid_a && !f_ready) || (cap2 && valid_b && !(f_ready && !valid_a))) begin
        overflow <= 1'b1;
      end
    end
  end
  // ----------------------------------------------------------------
  // output fifo
  // ----------------------------------------------------------------
  vipd_fifo #(
    .WIDTH(36),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(f_valid),
    .in_ready(f_ready),
    .in_data(f_data),
    .out_valid(pix_valid),
    .out_ready(pix_ready),
    .out_data(pix_data)
  );
endmodule // vipd_port

// [tb/vipd_port_sva.sv]
/* checker of vipd_port port relations.
   assumes bind to vipd_port, one clock, srst sync active high. */
`timescale 1ns/1ps
module vipd_port_sva (
  input wire clk,
  input wire srst,
  input wire [7:0] cfg_input,
  input wire [7:0] sd_format,
  input wire sd_rgb_select,
  input wire hd_rgb_select,
  input wire [2:0] mode,
  input wire mode_reserved,
  input wire [1:0] sd_data_format,
  input wire embedded_sync_allowed,
  input wire pix_valid,
  input wire pix_ready,
  input wire [35:0] pix_data,
  input wire overflow
);
  wire [2:0] cfg_mode = cfg_input[6:4];
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_MODE: assert property (!$past(srst) |-> mode == $past(cfg_mode)) else $error("mode lags config");
  AST_RST: assert property ($fell(srst) |-> mode == 3'h0) else $error("mode not sd after reset");
  AST_RSVD: assert property (mode_reserved == (mode == 3'h5 || mode == 3'h6)) else $error("reserved flag");
  AST_SDF: assert property (sd_data_format == sd_format[4:3]) else $error("sd format field");
  AST_ESA_SD: assert property ((mode == 3'h0 && (sd_rgb_select || sd_format[3])) |-> !embedded_sync_allowed)
    else $error("sd embedded sync");
  AST_ESA_HD: assert property ((mode == 3'h1 && hd_rgb_select) |-> !embedded_sync_allowed)
    else $error("hd embedded sync");
  AST_HOLD: assert property ((pix_valid && !pix_ready) |=> pix_valid && $stable(pix_data)) else $error("word dropped");
  AST_OVF: assert property (overflow |=> overflow) else $error("overflow not sticky");
  AST_QUIET: assert property (mode_reserved [*8] ##0 !pix_valid |=> !pix_valid) else $error("reserved captured");
  AST_DDR: assert property ((pix_valid && pix_data[34]) |-> pix_data[35] && pix_data[33:32] == 2'h0)
    else $error("dual rate word format");
  // ----------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------
  cover property (pix_valid && pix_ready && pix_data[34]);
  cover property ($rose(overflow));
  cover property (mode_reserved && !pix_valid);
endmodule // vipd_port_sva
bind vipd_port vipd_port_sva i_sva (.clk(clk), .srst(srst), .cfg_input(cfg_input), .sd_format(sd_format),
  .sd_rgb_select(sd_rgb_select), .hd_rgb_select(hd_rgb_select), .mode(mode), .mode_reserved(mode_reserved),
  .sd_data_format(sd_data_format), .embedded_sync_allowed(embedded_sync_allowed), .pix_valid(pix_valid),
  .pix_ready(pix_ready), .pix_data(pix_data), .overflow(overflow));

// [tb/vipd_source.sv]
/* video source model: pixel clocks, s/y/c buses and sync pins.
   assumes the port oversamples; clocks stand still between transfers. */
`timescale 1ns/1ps
module vipd_source (
  input wire clk,
  output logic clk_a,
  output logic clk_b,
  output logic [7:0] s,
  output logic [7:0] y,
  output logic [7:0] c,
  output logic [2:0] sd_sync,
  output logic [2:0] hd_sync
);
  initial begin
    clk_a = 1'b0;
    clk_b = 1'b0;
    {s, y, c} = 24'h0;
    sd_sync = 3'h5;
    hd_sync = 3'h2;
  end
  // one pixel clock period, then data held no longer
  task automatic send(input logic [7:0] vs, input logic [7:0] vy, input logic [7:0] vc, input logic on_b);
    @(posedge clk);
    #1 {s, y, c} = {vs, vy, vc};
    repeat (8) @(posedge clk);
    #1;
    if (on_b) clk_b = 1'b1;
    else clk_a = 1'b1;
    repeat (12) @(posedge clk);
    #1 {clk_a, clk_b} = 2'b00;
    repeat (12) @(posedge clk);
    #1 {s, y, c} = ~{vs, vy, vc};
  endtask
endmodule // vipd_source

// [tb/video_input_port_demux_bench.sv]
/* self-checking bench of vipd_port: mode table, dual rate, reserved codes, fifo fill.
   assumes vipd_source drives the pins; 125 MHz clk. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module video_input_port_demux_bench;
  typedef struct packed {logic [7:0] cfg; logic [7:0] sdf; logic [2:0] sel; logic path;
    logic [1:0] fmt; logic [2:0] mask; logic esa;} vipd_row_t;
  logic clk = 0, srst = 1, sr = 0, hr = 0, h4 = 0, pix_ready = 0;
  logic [7:0] cfg = 0, sdf = 0, s, y, c;
  logic clk_a, clk_b, mode_reserved, esa, pix_valid, overflow;
  logic [2:0] sds, hds, mode;
  logic [1:0] sd_data_format;
  logic [35:0] pix_data, w;
  int n_mismatch = 0, comparisons = 0, cyc = 0, n;
  vipd_row_t r;
  vipd_row_t rows [10] = '{{8'h00, 8'h10, 4'h0, 2'h0, 3'h4, 1'b1}, {8'h80, 8'h00, 4'h0, 2'h0, 3'h2, 1'b1},
    {8'h00, 8'h08, 4'h0, 2'h1, 3'h6, 1'b0}, {8'h80, 8'h08, 4'h0, 2'h1, 3'h3, 1'b0},
    {8'h00, 8'h00, 4'h8, 2'h3, 3'h7, 1'b0}, {8'h10, 8'h00, 4'h3, 2'h1, 3'h3, 1'b1},
    {8'h10, 8'h00, 4'h1, 2'h2, 3'h7, 1'b1}, {8'h10, 8'h00, 4'h5, 2'h3, 3'h7, 1'b0},
    {8'h30, 8'h00, 4'h0, 2'h0, 3'h4, 1'b1}, {8'h70, 8'h00, 4'h1, 2'h0, 3'h2, 1'b1}};
  vipd_source i_src (.clk(clk), .clk_a(clk_a), .clk_b(clk_b), .s(s), .y(y), .c(c), .sd_sync(sds), .hd_sync(hds));
  vipd_port #(.FIFO_DEPTH(32), .FIFO_AW(5)) i_dut (.clk(clk), .srst(srst), .cfg_input(cfg), .sd_format(sdf),
    .sd_rgb_select(sr), .hd_rgb_select(hr), .hd_422_select(h4), .primary_pixel_clock_pin(clk_a),
    .secondary_pixel_clock_pin(clk_b), .s_pixel_bus(s), .y_pixel_bus(y), .c_pixel_bus(c), .sd_sync_pins(sds),
    .hd_sync_pins(hds), .mode(mode), .mode_reserved(mode_reserved), .sd_data_format(sd_data_format),
    .embedded_sync_allowed(esa), .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_data(pix_data),
    .overflow(overflow));
  always #4 clk = ~clk;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task tally_and_finish;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  function automatic logic has(input logic [7:0] b);
    return w[7:0] === b || w[15:8] === b || w[23:16] === b;
  endfunction
  task automatic get;
    int k = 0;
    while (pix_valid !== 1'b1 && k < 60) begin
      @(posedge clk);
      #1 k++;
    end
    w = pix_data;
    pix_ready = 1;
    @(posedge clk);
    #1 pix_ready = 0;
  endtask
  task automatic chk_word(input logic p, input logic [1:0] f, input logic d, input logic [2:0] m);
    `CHK("path", p, w[35])
    `CHK("fmt", f, w[33:32])
    `CHK("ddr", d, w[34])
    `CHK("sync", p ? 3'h2 : 3'h5, w[26:24])
    `CHK("bus", m, {has(8'hA1), has(8'hB2), has(8'hC3)} & m)
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    #1 srst = 0;
    `CHK("mode", 3'h0, mode)
    foreach (rows[j]) begin
      r = rows[j];
      {cfg, sdf, sr, hr, h4} = {r.cfg, r.sdf, r.sel};
      repeat (2) @(posedge clk);
      #1 `CHK("mode", r.cfg[6:4], mode)
      `CHK("esa", r.esa, esa)
      `CHK("sdfmt", r.sdf[4:3], sd_data_format)
      i_src.send(8'hA1, 8'hB2, 8'hC3, 1'b0);
      get();
      chk_word(r.path, r.fmt, 1'b0, r.mask);
    end
    {sr, hr, h4} = 3'h0;
    for (int j = 0; j < 4; j++) begin
      cfg = j[1] ? (j[0] ? 8'h40 : 8'h30) : (j[0] ? 8'h22 : 8'h20);
      i_src.send(8'hA1, 8'hB2, 8'hC3, j[1]);
      get();
      chk_word(1'b1, j == 2 ? 2'h1 : 2'h0, j == 1, j == 2 ? 3'h3 : 3'h2);
      if (j != 2) get();
      if (j != 2) chk_word(1'b1, 2'h0, j != 1, 3'h2);
    end
    for (int j = 5; j < 7; j++) begin
      cfg = {1'b0, j[2:0], 4'h0};
      repeat (2) @(posedge clk);
      #1 `CHK("rsvd", 1'b1, mode_reserved)
      i_src.send(8'hA1, 8'hB2, 8'hC3, 1'b0);
      `CHK("quiet", 1'b0, pix_valid)
    end
    cfg = 8'h00;
    // fifo of 32 plus the capture register hold 33 words
    repeat (33) i_src.send(8'hA1, 8'hB2, 8'hC3, 1'b0);
    `CHK("ovf", 1'b0, overflow)
    i_src.send(8'hA1, 8'hB2, 8'hC3, 1'b0);
    `CHK("ovf", 1'b1, overflow)
    pix_ready = 1;
    n = 0;
    repeat (40) begin
      if (pix_valid) n++;
      @(posedge clk);
      #1;
    end
    `CHK("drained", 32 + 1, n)
    {pix_ready, cfg, srst} = {1'b0, 8'h70, 1'b1};
    repeat (3) @(posedge clk);
    #1 srst = 0;
    `CHK("mode", 3'h0, mode)
    `CHK("ovf", 1'b0, overflow)
    `CHK("valid", 1'b0, pix_valid)
    tally_and_finish();
  end
endmodule // video_input_port_demux_bench
